// File: verilog/cfg_ctrl.sv
// configuration control and upgrade status block with apb registers
//
// Functional notes
// - scheme taken from static mode-select pins
// - restart low in user mode resets, tristates
// - restart rising edge starts new configuration
// - status line low until power-on time
// - configuration error pulls status line low
// - external status low while configuring: error
// - status line ignored in user mode
// - restart or watchdog expiry forces reconfiguration
// - status word top bits hold state
// - factory layout: zero pad, boot address
// - app layout one: watchdog enable, timeout
// - app layout two: zero pad, address
// - layout follows factory or application image
// - two previous application states kept
`timescale 1ns/1ps
`include "cfg_ctrl_consts.svh"
module cfg_ctrl (
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic [2:0] SCHEME_SELECT_PINS,
    input wire logic CONFIG_RESTART_N,
    input wire logic STATUS_IN,
    output logic STATUS_OUT,
    output logic STATUS_OE,
    output logic USER_IO_OE,
    output logic CONFIG_DONE,
    output logic [2:0] SCHEME,
    output logic IRQ,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    localparam logic [15:0] POR_CNT = 16'(`POR_CYCLES);
    localparam logic [15:0] INIT_CNT = 16'(`INIT_CYCLES);

    // ==========================================================
    // pin synchronisers
    logic restart_n_s;
    logic status_in_s;
    logic [2:0] scheme_s;
    sync2 u_sync_restart (.clk(CLK_SYS), .rst_n(NRST),
        .d(CONFIG_RESTART_N), .q(restart_n_s));
    sync2 u_sync_status (.clk(CLK_SYS), .rst_n(NRST),
        .d(STATUS_IN), .q(status_in_s));
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_scheme_select_pins
            sync2 u_sync_scheme_select_pins (.clk(CLK_SYS), .rst_n(NRST),
                .d(SCHEME_SELECT_PINS[gi]), .q(scheme_s[gi]));
        end
    endgenerate

    logic restart_prev_r;
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            restart_prev_r <= 1'b1;
        end else begin
            restart_prev_r <= restart_n_s;
        end
    end
    logic restart_rise;
    logic restart_fall;
    assign restart_rise = restart_n_s && !restart_prev_r;
    assign restart_fall = !restart_n_s && restart_prev_r;

    // ==========================================================
    // apb decode
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit
    logic wr_en;
    logic rd_en;
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && PENABLE && !PWRITE;

    // ==========================================================
    // software control
    logic load_done_r;
    logic cfg_err_req_r;
    logic app_layout2_r;
    logic wd_kick_r;
    logic wd_en_r;
    logic [28:0] wd_timeout_r;
    logic [23:0] boot_addr_r;
    logic [`IRQ_BITS-1:0] irq_en_r;
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            load_done_r <= 1'b0;
            cfg_err_req_r <= 1'b0;
            wd_kick_r <= 1'b0;
            app_layout2_r <= 1'b0;
            irq_en_r <= '0;
        end else begin
            load_done_r <= 1'b0;
            cfg_err_req_r <= 1'b0;
            wd_kick_r <= 1'b0;
            if (wr_en && hit(PADDR, `OFF_CTRL)) begin
                load_done_r <= PWDATA[`CTRL_LOAD_DONE];
                cfg_err_req_r <= PWDATA[`CTRL_CFG_ERROR];
                app_layout2_r <= PWDATA[`CTRL_APP_LAYOUT2];
                wd_kick_r <= PWDATA[`CTRL_WD_KICK];
            end else if (wr_en && hit(PADDR, `OFF_IRQ_ENABLE)) begin
                irq_en_r <= PWDATA[`IRQ_BITS-1:0];
            end
        end
    end

    // ==========================================================
    // configuration state machine
    cfg_ctrl_pkg::cfg_state_e state_r;
    cfg_ctrl_pkg::upg_code_e upg_r;
    logic [15:0] cnt_r;
    logic [28:0] wd_cnt_r;
    logic wd_expire;
    logic ext_err;
    logic oe_d1_r; // own drive still in flight through the synchroniser
    logic oe_d2_r;
    assign wd_expire = (state_r == cfg_ctrl_pkg::ST_USER) && wd_en_r && (wd_cnt_r == 29'h0);
    assign ext_err = !status_in_s && !STATUS_OE && !oe_d1_r && !oe_d2_r &&
        (state_r == cfg_ctrl_pkg::ST_CONFIG || state_r == cfg_ctrl_pkg::ST_INIT);

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            state_r <= cfg_ctrl_pkg::ST_POR;
            cnt_r <= '0;
        end else begin
            case (state_r)
                cfg_ctrl_pkg::ST_POR: begin
                    if (cnt_r >= POR_CNT - 16'h1) begin
                        state_r <= restart_n_s ? cfg_ctrl_pkg::ST_CONFIG
                            : cfg_ctrl_pkg::ST_RESET;
                        cnt_r <= '0;
                    end else begin
                        cnt_r <= cnt_r + 16'h1;
                    end
                end
                cfg_ctrl_pkg::ST_RESET: begin
                    if (restart_rise) begin
                        state_r <= cfg_ctrl_pkg::ST_CONFIG;
                    end
                end
                cfg_ctrl_pkg::ST_CONFIG: begin
                    if (restart_fall) begin
                        state_r <= cfg_ctrl_pkg::ST_RESET;
                    end else if (cfg_err_req_r || ext_err) begin
                        state_r <= cfg_ctrl_pkg::ST_ERROR;
                    end else if (load_done_r) begin
                        state_r <= cfg_ctrl_pkg::ST_INIT;
                        cnt_r <= '0;
                    end
                end
                cfg_ctrl_pkg::ST_INIT: begin
                    if (restart_fall) begin
                        state_r <= cfg_ctrl_pkg::ST_RESET;
                    end else if (ext_err) begin
                        state_r <= cfg_ctrl_pkg::ST_ERROR;
                    end else if (cnt_r >= INIT_CNT - 16'h1) begin
                        state_r <= cfg_ctrl_pkg::ST_USER;
                    end else begin
                        cnt_r <= cnt_r + 16'h1;
                    end
                end
                cfg_ctrl_pkg::ST_USER: begin
                    // status line not looked at here
                    if (restart_fall) begin
                        state_r <= cfg_ctrl_pkg::ST_RESET;
                    end else if (wd_expire) begin
                        state_r <= cfg_ctrl_pkg::ST_CONFIG;
                    end
                end
                cfg_ctrl_pkg::ST_ERROR: begin
                    if (restart_fall) begin
                        state_r <= cfg_ctrl_pkg::ST_RESET;
                    end
                end
                default: state_r <= cfg_ctrl_pkg::ST_POR;
            endcase
        end
    end

    // ==========================================================
    // watchdog
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            wd_cnt_r <= `WD_DEFAULT;
        end else if (state_r != cfg_ctrl_pkg::ST_USER || wd_kick_r || wd_expire) begin
            wd_cnt_r <= wd_timeout_r;
        end else if (wd_en_r) begin
            wd_cnt_r <= wd_cnt_r - 29'h1;
        end
    end

    // ==========================================================
    // upgrade state, captured image info and history
    logic entering_config;
    assign entering_config = state_r != cfg_ctrl_pkg::ST_CONFIG &&
        ((state_r == cfg_ctrl_pkg::ST_USER && wd_expire) ||
         (state_r == cfg_ctrl_pkg::ST_RESET && restart_rise));
    logic [31:0] status_word;
    logic [31:0] prev1_r;
    logic [31:0] prev2_r;
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            upg_r <= cfg_ctrl_pkg::UPG_FACTORY;
            prev1_r <= '0;
            prev2_r <= '0;
            boot_addr_r <= `BOOT_DEFAULT;
            wd_en_r <= 1'b0;
            wd_timeout_r <= `WD_DEFAULT;
        end else if (state_r == cfg_ctrl_pkg::ST_CONFIG && wr_en && hit(PADDR, `OFF_SCHEME)) begin
            // image parameters only loadable while configuring
            boot_addr_r <= PWDATA[23:0];
            wd_en_r <= PWDATA[`FLD_WD_EN];
            wd_timeout_r <= PWDATA[28:0];
            upg_r <= PWDATA[31] ? cfg_ctrl_pkg::UPG_APP : cfg_ctrl_pkg::UPG_FACTORY;
        end else if (entering_config && upg_r == cfg_ctrl_pkg::UPG_APP) begin
            prev2_r <= prev1_r;
            prev1_r <= status_word;
        end
    end

    always_comb begin
        status_word = '0;
        status_word[`FLD_STATE_HI:`FLD_STATE_LO] = upg_r;
        if (upg_r == cfg_ctrl_pkg::UPG_FACTORY) begin
            status_word[23:0] = boot_addr_r;
        end else if (!app_layout2_r) begin
            status_word[`FLD_WD_EN] = wd_en_r;
            status_word[28:0] = wd_timeout_r;
        end else begin
            status_word[23:0] = boot_addr_r;
        end
    end

    // ==========================================================
    // interrupts
    logic [`IRQ_BITS-1:0] irq_st_r;
    logic [`IRQ_BITS-1:0] irq_evt;
    logic [`IRQ_BITS-1:0] irq_clr;
    assign irq_evt[`IRQ_RESTART] = restart_rise;
    assign irq_evt[`IRQ_WD_EXPIRE] = wd_expire;
    assign irq_evt[`IRQ_CFG_ERROR] = state_r == cfg_ctrl_pkg::ST_CONFIG && cfg_err_req_r;
    assign irq_evt[`IRQ_EXT_STATUS] = ext_err;
    assign irq_evt[`IRQ_USER_MODE] = state_r == cfg_ctrl_pkg::ST_INIT && cnt_r >= INIT_CNT - 16'h1;
    assign irq_clr = (wr_en && hit(PADDR, `OFF_IRQ_CLEAR)) ? PWDATA[`IRQ_BITS-1:0] : '0;
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            irq_st_r <= '0;
        end else begin
            irq_st_r <= (irq_st_r & ~irq_clr) | irq_evt;
        end
    end
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(((irq_st_r & ~irq_clr) | irq_evt) & irq_en_r);
        end
    end

    // ==========================================================
    // pin outputs
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            STATUS_OUT <= 1'b0;
            STATUS_OE <= 1'b1;
            USER_IO_OE <= 1'b0;
            CONFIG_DONE <= 1'b0;
            SCHEME <= 3'h0;
            oe_d1_r <= 1'b1;
            oe_d2_r <= 1'b1;
        end else begin
            STATUS_OUT <= 1'b0;
            oe_d1_r <= STATUS_OE;
            oe_d2_r <= oe_d1_r;
            STATUS_OE <= (state_r == cfg_ctrl_pkg::ST_POR && cnt_r < POR_CNT - 16'h1) ||
                state_r == cfg_ctrl_pkg::ST_ERROR ||
                (state_r == cfg_ctrl_pkg::ST_CONFIG && cfg_err_req_r);
            USER_IO_OE <= state_r == cfg_ctrl_pkg::ST_USER && restart_n_s;
            CONFIG_DONE <= state_r == cfg_ctrl_pkg::ST_USER;
            if (state_r == cfg_ctrl_pkg::ST_POR || state_r == cfg_ctrl_pkg::ST_RESET) begin
                SCHEME <= scheme_s;
            end
        end
    end

    // ==========================================================
    // apb read
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            PRDATA <= '0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            PRDATA <= '0;
            if (PSEL && !PENABLE) begin
                if (hit(PADDR, `OFF_UPGRADE_CURRENT_STATE)) begin
                    PRDATA <= status_word;
                end else if (hit(PADDR, `OFF_PREV_STATE_1)) begin
                    PRDATA <= prev1_r;
                end else if (hit(PADDR, `OFF_PREV_STATE_2)) begin
                    PRDATA <= prev2_r;
                end else if (hit(PADDR, `OFF_CTRL)) begin
                    PRDATA <= {29'h0, app_layout2_r, 2'h0};
                end else if (hit(PADDR, `OFF_IRQ_STATUS)) begin
                    PRDATA <= {27'h0, irq_st_r};
                end else if (hit(PADDR, `OFF_IRQ_ENABLE)) begin
                    PRDATA <= {27'h0, irq_en_r};
                end else if (hit(PADDR, `OFF_SCHEME)) begin
                    PRDATA <= {26'h0, state_r, SCHEME};
                end else if (!hit(PADDR, `OFF_IRQ_CLEAR)) begin
                    PSLVERR <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // checks
    logic unused_rd;
    assign unused_rd = rd_en;
    por_release_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        $rose(state_r != cfg_ctrl_pkg::ST_POR) |-> ##1 !STATUS_OE)
        else $error("status line not released after power-on time");
    user_oe_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (state_r == cfg_ctrl_pkg::ST_RESET) |=> !USER_IO_OE)
        else $error("user io driven during reset");
    restart_cfg_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (state_r == cfg_ctrl_pkg::ST_RESET && restart_rise) |=> state_r == cfg_ctrl_pkg::ST_CONFIG)
        else $error("restart release did not start configuration");
    ext_err_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        ext_err && !restart_fall |=> state_r == cfg_ctrl_pkg::ST_ERROR)
        else $error("external status low did not cause error");
    err_drive_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        state_r == cfg_ctrl_pkg::ST_ERROR |=> STATUS_OE && !STATUS_OUT)
        else $error("error not reported on status line");
    user_ignore_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        state_r == cfg_ctrl_pkg::ST_USER && restart_n_s && !wd_expire |=>
        state_r == cfg_ctrl_pkg::ST_USER)
        else $error("user mode left without cause");
    wd_reload_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        wd_expire && !restart_fall |=> state_r == cfg_ctrl_pkg::ST_CONFIG)
        else $error("watchdog expiry did not reconfigure");
    state_bits_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        status_word[31:30] == upg_r)
        else $error("state code missing from status word");
    pad_zero_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (upg_r == cfg_ctrl_pkg::UPG_FACTORY || app_layout2_r) |-> status_word[29:24] == 6'h00)
        else $error("padding bits not zero");
    hist_hold_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        !entering_config |=> $stable(prev1_r) && $stable(prev2_r))
        else $error("previous state changed between reconfigurations");
endmodule : cfg_ctrl

// File: pkg/cfg_ctrl_consts.svh
// offsets, fields, reset values and timing counts of the configuration control block
`ifndef CFG_CTRL_CONSTS_SVH
`define CFG_CTRL_CONSTS_SVH
`define OFF_UPGRADE_CURRENT_STATE 12'h000
`define OFF_PREV_STATE_1 12'h004
`define OFF_PREV_STATE_2 12'h008
`define OFF_CTRL 12'h00C
`define OFF_IRQ_STATUS 12'h010
`define OFF_IRQ_ENABLE 12'h014
`define OFF_IRQ_CLEAR 12'h018
`define OFF_SCHEME 12'h01C
`define FLD_STATE_HI 31
`define FLD_STATE_LO 30
`define FLD_WD_EN 29
`define CTRL_LOAD_DONE 0
`define CTRL_CFG_ERROR 1
`define CTRL_APP_LAYOUT2 2
`define CTRL_WD_KICK 3
`define IRQ_RESTART 0
`define IRQ_WD_EXPIRE 1
`define IRQ_CFG_ERROR 2
`define IRQ_EXT_STATUS 3
`define IRQ_USER_MODE 4
`define IRQ_BITS 5
`define POR_TIME_NS 1000
`define CLK_PERIOD_NS 4
`define POR_CYCLES ((`POR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_CYCLES 16
`define WD_DEFAULT 29'h0000_1000
`define BOOT_DEFAULT 24'h00_0000
`endif

// File: pkg/cfg_ctrl_pkg.sv
// types of the configuration control block
package cfg_ctrl_pkg;
    typedef enum logic [2:0] {
        ST_POR = 3'b000,
        ST_RESET = 3'b001,
        ST_CONFIG = 3'b011,
        ST_INIT = 3'b010,
        ST_USER = 3'b110,
        ST_ERROR = 3'b111
    } cfg_state_e;
    typedef enum logic [1:0] {
        UPG_FACTORY = 2'h0,
        UPG_APP = 2'h1
    } upg_code_e;
endpackage : cfg_ctrl_pkg

// File: verilog/sync2.sv
// two-flop synchroniser for a level
`timescale 1ns/1ps
module sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b1;
            q <= 1'b1;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : sync2

// File: testbench/cfg_host_model.sv
// far-side host model: restart driver and open-drain status wire
`timescale 1ns/1ps
module cfg_host_model (
    input wire logic clk,
    input wire logic status_oe,
    input wire logic status_out,
    output logic restart_n,
    output logic status_wire
);
    // ==========================================
    // drive state
    logic pull_r;
    initial begin
        restart_n = 1'b1;
        pull_r = 1'b0;
    end
    // ==========================================
    // wire resolution, pull-up when nobody drives
    assign status_wire = ((status_oe && !status_out) || pull_r) ? 1'b0 : 1'b1;
    // ==========================================
    // requests, changed just after a clock edge
    task drive_restart(input logic v);
        restart_n <= v;
    endtask : drive_restart
    task drive_pull(input logic v);
        pull_r <= v;
    endtask : drive_pull
endmodule : cfg_host_model

// File: testbench/testbench.sv
// self-checking bench for the configuration control block
`timescale 1ns/1ps
`include "cfg_ctrl_consts.svh"
module testbench;
    // ==========================================
    // clock, reset, wiring
    logic [2:0] straps = 3'h5;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic status_out, status_oe, user_io_oe, config_done, irq, pready, pslverr;
    logic restart_n, status_wire;
    logic [2:0] scheme;
    logic [31:0] prdata;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    always #2 clk_sys = ~clk_sys;
    cfg_ctrl DUT (.CLK_SYS(clk_sys), .NRST(nrst), .SCHEME_SELECT_PINS(straps),
        .CONFIG_RESTART_N(restart_n), .STATUS_IN(status_wire), .STATUS_OUT(status_out),
        .STATUS_OE(status_oe), .USER_IO_OE(user_io_oe), .CONFIG_DONE(config_done),
        .SCHEME(scheme), .IRQ(irq), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    cfg_host_model HOST (.clk(clk_sys), .status_oe(status_oe), .status_out(status_out),
        .restart_n(restart_n), .status_wire(status_wire));
    // ==========================================
    // checks and report
    task summarize;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task chk1(input string name, input logic exp, input logic got);
        chk(name, {31'h0000_0000, exp}, {31'h0000_0000, got});
    endtask : chk1
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    // ==========================================
    // apb master, entered just after a rising edge
    task apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_sys);
        end
        chk1("apb answer", 1'b1, pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task wr(input logic [11:0] addr, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, addr, wd, d, e);
    endtask : wr
    task rd(input string name, input logic [11:0] addr, input logic [31:0] exp,
        input logic [31:0] mask);
        logic [31:0] d;
        logic e;
        apb(1'b0, addr, 32'h0000_0000, d, e);
        chk(name, exp & mask, d & mask);
    endtask : rd
    task wait_done(input logic v, input int lim);
        int n;
        n = 0;
        while (config_done !== v && n < lim) begin
            n++;
            @(posedge clk_sys);
        end
        chk1("config done", v, config_done);
    endtask : wait_done
    task idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : idle
    // ==========================================
    // test sequence
    initial begin
        logic [31:0] d;
        logic e;
        int n;
        idle(12);
        chk1("status drive in reset", 1'b1, status_oe);
        nrst <= 1'b1;
        idle(240);
        chk1("status held low", 1'b1, status_oe);
        n = 0;
        while (status_oe !== 1'b0 && n < 40) begin
            n++;
            @(posedge clk_sys);
        end
        chk1("status released", 1'b0, status_oe);
        chk1("status drive value", 1'b0, status_out);
        chk("scheme", 32'h0000_0005, {29'h0000_0000, scheme});
        rd("irq enable reset", `OFF_IRQ_ENABLE, 32'h0000_0000, 32'hFFFF_FFFF);
        apb(1'b0, 12'h020, 32'h0000_0000, d, e);
        chk1("unmapped error", 1'b1, e);
        idle(20);
        // factory image
        wr(`OFF_SCHEME, 32'h0012_3456);
        wr(`OFF_CTRL, 32'h0000_0001);
        wait_done(1'b1, 100);
        chk1("user io enable", 1'b1, user_io_oe);
        rd("factory word", `OFF_UPGRADE_CURRENT_STATE,
            {cfg_ctrl_pkg::UPG_FACTORY, 30'h0012_3456}, 32'hFFFF_FFFF);
        idle(50);
        rd("factory reread", `OFF_UPGRADE_CURRENT_STATE,
            {cfg_ctrl_pkg::UPG_FACTORY, 30'h0012_3456}, 32'hFFFF_FFFF);
        rd("user mode event", `OFF_IRQ_STATUS, 32'h0000_0010, 32'h0000_0010);
        wr(`OFF_IRQ_ENABLE, 32'h0000_0010);
        idle(3);
        chk1("irq raised", 1'b1, irq);
        wr(`OFF_IRQ_CLEAR, 32'h0000_0010);
        idle(3);
        chk1("irq cleared", 1'b0, irq);
        wr(`OFF_IRQ_ENABLE, 32'h0000_0000);
        // status pulse in user mode is ignored
        HOST.drive_pull(1'b1);
        idle(10);
        HOST.drive_pull(1'b0);
        idle(10);
        chk1("done after status pulse", 1'b1, config_done);
        // restart in user mode
        HOST.drive_restart(1'b0);
        straps <= 3'h2;
        idle(10);
        chk1("user io off in restart", 1'b0, user_io_oe);
        chk1("done off in restart", 1'b0, config_done);
        HOST.drive_restart(1'b1);
        idle(20);
        rd("restart event", `OFF_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
        chk("scheme relatched", 32'h0000_0002, {29'h0000_0000, scheme});
        wr(`OFF_IRQ_ENABLE, 32'h0000_0001);
        idle(3);
        chk1("irq restart", 1'b1, irq);
        wr(`OFF_IRQ_ENABLE, 32'h0000_0000);
        idle(3);
        chk1("irq masked", 1'b0, irq);
        wr(`OFF_IRQ_CLEAR, 32'h0000_001F);
        // application image, watchdog enabled
        wr(`OFF_SCHEME, 32'hA000_0100);
        wr(`OFF_CTRL, 32'h0000_0001);
        wait_done(1'b1, 100);
        rd("app layout one", `OFF_UPGRADE_CURRENT_STATE,
            {cfg_ctrl_pkg::UPG_APP, 1'b1, 29'h0000_0100}, 32'hFFFF_FFFF);
        wr(`OFF_CTRL, 32'h0000_0004);
        rd("app layout two", `OFF_UPGRADE_CURRENT_STATE,
            {cfg_ctrl_pkg::UPG_APP, 6'h00, 24'h00_0100}, 32'hFFFF_FFFF);
        idle(200);
        wr(`OFF_CTRL, 32'h0000_000C);
        idle(100);
        chk1("kick holds user mode", 1'b1, config_done);
        wait_done(1'b0, 600);
        rd("watchdog event", `OFF_IRQ_STATUS, 32'h0000_0002, 32'h0000_0002);
        rd("previous state", `OFF_PREV_STATE_1, {cfg_ctrl_pkg::UPG_APP, 30'h0000_0000},
            32'hC000_0000);
        idle(20);
        // configuration error
        wr(`OFF_CTRL, 32'h0000_0002);
        idle(5);
        chk1("error drives status", 1'b1, status_oe);
        rd("error event", `OFF_IRQ_STATUS, 32'h0000_0004, 32'h0000_0004);
        HOST.drive_restart(1'b0);
        idle(10);
        HOST.drive_restart(1'b1);
        idle(20);
        rd("previous state two", `OFF_PREV_STATE_2, {cfg_ctrl_pkg::UPG_APP, 30'h0000_0000},
            32'hC000_0000);
        // external status low while configuring
        HOST.drive_pull(1'b1);
        idle(5);
        HOST.drive_pull(1'b0);
        idle(5);
        rd("external status event", `OFF_IRQ_STATUS, 32'h0000_0008, 32'h0000_0008);
        wr(`OFF_CTRL, 32'h0000_0001);
        idle(40);
        chk1("no user mode after error", 1'b0, config_done);
        summarize();
    end
endmodule : testbench
